// file: test/mcrc_periph_model.sv
// Peripheral and processor model: instruction pulses and external clock pin
`timescale 1ns/1ps
`default_nettype none
module mcrc_periph_model (
   input wire logic pclk,
   input wire logic ext_on,
   output var logic cpu_instr_done,
   output var logic external_clock_input
);
   logic [1:0] div_q;
   initial begin
      cpu_instr_done = 1'b0;
      external_clock_input = 1'b0;
      div_q = 2'h0;
   end
   // Pin runs at a quarter of pclk while ext_on is high; stands low otherwise, no edges to count
   always @(posedge pclk) begin
      div_q <= ext_on ? div_q + 2'h1 : 2'h0;
      external_clock_input <= ext_on & div_q[1];
   end
   // Retires n instructions after the key; four or more close the window
   task automatic retire(input int n);
      repeat (n) begin
         @(posedge pclk);
         cpu_instr_done <= 1'b1;
         @(posedge pclk);
         cpu_instr_done <= 1'b0;
      end
   endtask : retire
endmodule : mcrc_periph_model
`default_nettype wire

// file: test/mcrc_tb_top.sv
// Testbench for the main clock request controller
`timescale 1ns/1ps
`default_nettype none
module mcrc_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_on = 1'b0, clk_en = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, cpu_instr_done, external_clock_input, periph_main_req = 1'b0;
   logic counter_enabled = 1'b0, counter_uses_ext = 1'b0, watchdog_enabled = 1'b0;
   logic brownout_sampled = 1'b0, memory_busy = 1'b0, fast_osc_en, slow_osc_en, ext_pin_clock_mode;
   logic main_clk_run, cpu_clk_en, per_clk_en, counter_clk_req, watchdog_clock_net_req, brownout_clock_net_req;
   logic [1:0] main_src_sel;
   int fail_count = 0, compares = 0, g;
   always #50 pclk = ~pclk;
   mcrc_periph_model pm (.pclk, .ext_on, .cpu_instr_done, .external_clock_input);
   mcrc_top #(.EXT_EDGES(2)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cpu_instr_done, .periph_main_req, .counter_enabled, .counter_uses_ext,
      .watchdog_enabled, .brownout_sampled, .memory_busy, .external_clock_input, .fast_osc_en, .slow_osc_en,
      .ext_pin_clock_mode, .main_clk_run, .cpu_clk_en, .per_clk_en, .main_src_sel, .counter_clk_req,
      .watchdog_clock_net_req, .brownout_clock_net_req);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(1'b0, 1'b1, "no pready");
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Key first, then the protected write while the window is open
   task automatic prot(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, mcrc_pkg::MCRC_KEY_OFF, {24'h0, mcrc_pkg::MCRC_IO_KEY});
      apb(1'b1, a, d);
   endtask : prot
   // Second tick spacing only: the first may straddle a divider change
   task automatic gap();
      @(negedge pclk);
      repeat (2) begin
         for (int n = 0; n < 200 && per_clk_en !== 1'b1; n++) @(negedge pclk);
         g = 0;
         do begin
            @(negedge pclk);
            g++;
         end while (per_clk_en !== 1'b1 && g < 200);
      end
   endtask : gap
   task automatic wsrc(input logic [1:0] s);
      for (int n = 0; n < 200 && main_src_sel !== s; n++) @(negedge pclk);
   endtask : wsrc
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset
   task automatic final_report();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      apb(1'b0, mcrc_pkg::MCRC_MAIN_STATUS_OFF, 32'h0);
      chk(rd, 32'h0000_0010, "status after reset");
      apb(1'b0, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h0);
      chk(rd, 32'h0000_0011, "prescale after reset");
      chk(main_src_sel, 2'h0, "source after reset");
      gap();
      chk(g, 6, "divide by six");
      $display("reset test done");
   endtask : t_reset
   task automatic t_protect();
      apb(1'b1, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h1);
      apb(1'b0, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h0);
      chk(rd, 32'h0000_0011, "unkeyed write");
      apb(1'b1, mcrc_pkg::MCRC_KEY_OFF, {24'h0, mcrc_pkg::MCRC_IO_KEY});
      pm.retire(3);
      apb(1'b1, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h3);
      apb(1'b0, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h0);
      chk(rd, 32'h0000_0003, "keyed write");
      apb(1'b1, mcrc_pkg::MCRC_KEY_OFF, {24'h0, mcrc_pkg::MCRC_IO_KEY});
      pm.retire(5);
      apb(1'b1, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h5);
      apb(1'b0, mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'h0);
      chk(rd, 32'h0000_0003, "late write");
      apb(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      chk(pslverr, 1'b0, "no slave error");
      gap();
      chk(g, 4, "peripheral tick");
      $display("protect test done");
   endtask : t_protect
   task automatic t_prescale();
      int cd[12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 0};
      int fa[12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1};
      for (int i = 0; i < 12; i++) begin
         prot(mcrc_pkg::MCRC_MAIN_CTRL_B_OFF, 32'(cd[i] * 2 + (i < 11)));
         gap();
         chk(g, fa[i], "prescale factor");
      end
      $display("prescale test done");
   endtask : t_prescale
   task automatic t_requests();
      logic [3:0] v[5] = '{4'b1000, 4'b1100, 4'b0010, 4'b0001, 4'b0000};
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         counter_enabled <= v[i][3];
         counter_uses_ext <= v[i][2];
         watchdog_enabled <= v[i][1];
         brownout_sampled <= v[i][0];
         repeat (4) @(negedge pclk);
         chk({counter_clk_req, watchdog_clock_net_req, brownout_clock_net_req}, {v[i][3], v[i][1], v[i][0]},
            "clock requests");
         chk(slow_osc_en, v[i][3] & ~v[i][2] | v[i][1] | v[i][0], "slow source");
         chk(ext_pin_clock_mode, v[i][3] & v[i][2], "pin clock mode");
      end
      // Clock enable low must freeze every request flop
      @(posedge pclk);
      clk_en <= 1'b0;
      watchdog_enabled <= 1'b1;
      repeat (4) @(negedge pclk);
      chk(watchdog_clock_net_req, 1'b0, "frozen by clock enable");
      @(posedge pclk);
      clk_en <= 1'b1;
      watchdog_enabled <= 1'b0;
      repeat (2) @(negedge pclk);
      chk(watchdog_clock_net_req, 1'b0, "request after enable");
      $display("request test done");
   endtask : t_requests
   task automatic t_switch();
      prot(mcrc_pkg::MCRC_MAIN_CTRL_A_OFF, 32'h1);
      wsrc(2'h1);
      chk(main_src_sel, 2'h1, "slow selected");
      chk({fast_osc_en, slow_osc_en, main_clk_run}, 3'b011, "unused fast off");
      prot(mcrc_pkg::MCRC_MAIN_CTRL_A_OFF, 32'h0);
      wsrc(2'h0);
      chk(main_src_sel, 2'h0, "fast again");
      $display("switch test done");
   endtask : t_switch
   task automatic t_sleep();
      logic [4:0] e[9] = '{5'b01001, 5'b10000, 5'b10101, 5'b11111, 5'b11100, 5'b00001, 5'b10001, 5'b11000,
         5'b00001};
      for (int i = 0; i < 9; i++) begin
         if (i == 6) prot(mcrc_pkg::MCRC_FAST_OSC_CTRL_OFF, 32'h2);
         @(posedge pclk);
         periph_main_req <= e[i][2];
         memory_busy <= e[i][1];
         apb(1'b1, mcrc_pkg::MCRC_SLEEP_CTRL_OFF, 32'(e[i][4:3]));
         repeat (4) @(negedge pclk);
         chk(main_clk_run, e[i][0], "main clock run");
         chk(cpu_clk_en, e[i][0], "cpu clock");
         chk(fast_osc_en, e[i][0], "fast oscillator");
      end
      $display("sleep test done");
   endtask : t_sleep
   task automatic t_ext();
      prot(mcrc_pkg::MCRC_MAIN_CTRL_A_OFF, 32'h3);
      apb(1'b0, mcrc_pkg::MCRC_MAIN_STATUS_OFF, 32'h0);
      chk(rd, 32'h0000_0011, "switch pending");
      chk({ext_pin_clock_mode, main_src_sel}, 3'b100, "waiting for edges");
      prot(mcrc_pkg::MCRC_MAIN_CTRL_A_OFF, 32'h1);
      repeat (20) @(negedge pclk);
      chk(main_src_sel, 2'h0, "change while pending");
      @(posedge pclk);
      ext_on <= 1'b1;
      wsrc(2'h3);
      chk(main_src_sel, 2'h3, "external selected");
      apb(1'b0, mcrc_pkg::MCRC_MAIN_STATUS_OFF, 32'h0);
      chk(rd, 32'h0000_0080, "external stable");
      apb(1'b0, mcrc_pkg::MCRC_MAIN_CTRL_A_OFF, 32'h0);
      chk(rd, 32'h0000_0003, "select kept");
      @(posedge pclk);
      ext_on <= 1'b0;
      repeat (30) @(negedge pclk);
      chk(main_src_sel, 2'h3, "no fallback");
      do_reset();
      @(negedge pclk);
      chk(main_src_sel, 2'h0, "reset returns fast");
      $display("external test done");
   endtask : t_ext
   // ----------------------------------------
   // Run and watchdog
   // ----------------------------------------
   initial begin
      do_reset();
      t_reset();
      t_protect();
      t_prescale();
      t_requests();
      t_switch();
      t_sleep();
      do_reset();
      t_ext();
      final_report();
   end
   initial begin
      #3_000_000;
      fail_count++;
      final_report();
   end
endmodule : mcrc_tb_top
`default_nettype wire

// file: verilog/mcrc_pkg.sv
// Package: constants and types for the main clock request controller
package mcrc_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] MCRC_MAIN_CTRL_A_OFF = 8'h00;
   localparam logic [7:0] MCRC_MAIN_CTRL_B_OFF = 8'h04;
   localparam logic [7:0] MCRC_MAIN_STATUS_OFF = 8'h08;
   localparam logic [7:0] MCRC_FAST_OSC_CTRL_OFF = 8'h0C;
   localparam logic [7:0] MCRC_SLOW_OSC_CTRL_OFF = 8'h10;
   localparam logic [7:0] MCRC_SLEEP_CTRL_OFF = 8'h14;
   localparam logic [7:0] MCRC_KEY_OFF = 8'h18;
   // ----------------------------------------
   // Keys, fields, reset values, counts
   // ----------------------------------------
   localparam logic [7:0] MCRC_IO_KEY = 8'hD8;
   localparam logic [2:0] MCRC_KEY_WINDOW = 3'h4;
   localparam logic [1:0] MCRC_SRC_FAST = 2'h0;
   localparam logic [1:0] MCRC_SRC_SLOW = 2'h1;
   localparam logic [1:0] MCRC_SRC_EXT = 2'h3;
   localparam int MCRC_PDIV_POS = 1;
   localparam logic [3:0] MCRC_PDIV_RST = 4'h8;
   localparam logic MCRC_PEN_RST = 1'b1;
   localparam logic [1:0] MCRC_EXT_START_CYC = 2'h2;
   localparam int MCRC_EXT_EDGES = 4;
   // ----------------------------------------
   // Sleep modes and switch states
   // ----------------------------------------
   typedef enum logic [1:0] {
      MCRC_SLP_ACTIVE = 2'b00,
      MCRC_SLP_IDLE = 2'b01,
      MCRC_SLP_STANDBY = 2'b10,
      MCRC_SLP_PDOWN = 2'b11
   } mcrc_sleep_t;
   typedef enum logic [1:0] {
      MCRC_SW_IDLE = 2'b00,
      MCRC_SW_WAIT = 2'b01,
      MCRC_SW_EXT = 2'b10
   } mcrc_sw_t;
endpackage : mcrc_pkg

// file: verilog/mcrc_top.sv
// Main clock request controller: requests, source switch, prescaler, APB
//
// Summary of operation
// [RULE_01] Peripheral requests enable clocks automatically
// [RULE_02] Route each request to configured source
// [RULE_03] Prescaler divides 1 to 64, twelve settings
// [RULE_04] Peripheral clock comes through the prescaler
// [RULE_05] Cpu net and peripheral net driven
// [RULE_06] Counter clock requested while counter enabled
// [RULE_07] Watchdog, sampled brownout request their clocks
// [RULE_08] Main source from source select field
// [RULE_09] Unused, unrequested sources are switched off
// [RULE_10] Standby-run bit keeps oscillator on
// [RULE_11] Main clock runs in active, idle
// [RULE_12] Standby: run only if requested or kept
// [RULE_13] Power-down waits for memory operations
// [RULE_14] Internal sources selectable, switch glitch-free
// [RULE_15] External switch waits for stable edges
// [RULE_16] Further changes ignored while switch waits
// [RULE_17] Pending flag while switch in progress
// [RULE_18] External stability flag in status
// [RULE_19] No automatic fallback from external source
// [RULE_20] Reset: fast oscillator, divide by six
// [RULE_21] Key then protected write within four
// [RULE_22] External input usable two cycles after request
// [RULE_23] Settings 1..64 plus 6,10,12,24,48
// [RULE_24] Fixed count of consecutive external edges
`timescale 1ns/1ps
`default_nettype none
module mcrc_top #(
   parameter int EXT_EDGES = mcrc_pkg::MCRC_EXT_EDGES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_instr_done,
   input wire logic periph_main_req,
   input wire logic counter_enabled,
   input wire logic counter_uses_ext,
   input wire logic watchdog_enabled,
   input wire logic brownout_sampled,
   input wire logic memory_busy,
   input wire logic external_clock_input,
   output logic fast_osc_en,
   output logic slow_osc_en,
   output logic ext_pin_clock_mode,
   output logic main_clk_run,
   output logic cpu_clk_en,
   output logic per_clk_en,
   output logic [1:0] main_src_sel,
   output logic counter_clk_req,
   output logic watchdog_clock_net_req,
   output logic brownout_clock_net_req
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] main_source_select;
      logic [1:0] active_src;
      logic [3:0] pdiv;
      logic pen;
      logic fast_keep;
      logic slow_keep;
      logic [1:0] sleep_mode;
      logic [2:0] key_cnt;
      mcrc_pkg::mcrc_sw_t sw;
      logic [7:0] edge_cnt;
      logic [1:0] ext_start;
      logic ext_sync1;
      logic ext_sync2;
      logic ext_prev;
      logic ext_stable;
      logic [5:0] div_cnt;
      logic per_tick;
      logic main_run;
      logic fast_en;
      logic slow_en;
      logic pin_mode;
      logic cnt_req;
      logic wdt_req;
      logic bod_req;
      logic [31:0] rdata;
      logic ready;
   } mcrc_state_t;

   mcrc_state_t st_q;
   mcrc_state_t st_d;

   // Last prescaler count (factor minus one), so divide by 64 fits six bits
   function automatic logic [5:0] mcrc_div(input logic [3:0] code, input logic en);
      logic [5:0] f;
      f = 6'h00;
      if (!en) begin
         f = 6'h00;
      end else begin
         case (code)
            4'h0: f = 6'h01;
            4'h1: f = 6'h03;
            4'h2: f = 6'h07;
            4'h3: f = 6'h0F;
            4'h4: f = 6'h1F;
            4'h5: f = 6'h3F;
            4'h8: f = 6'h05;
            4'h9: f = 6'h09;
            4'hA: f = 6'h0B;
            4'hB: f = 6'h17;
            4'hC: f = 6'h2F;
            default: f = 6'h00;
         endcase
      end
      return f; // [RULE_23]
   endfunction : mcrc_div

   logic setup;
   logic wr;
   logic prot_ok;
   logic ext_wanted;
   logic main_needed;
   logic [5:0] div_last;
   logic [31:0] rd;

   always_comb begin
      st_d = st_q;
      setup = psel && !penable;
      wr = psel && penable && pwrite && st_q.ready;
      prot_ok = st_q.key_cnt != 3'h0; // [RULE_21]
      rd = 32'h0000_0000;
      // ----------------------------------------
      // Register access, no wait states
      // ----------------------------------------
      st_d.ready = setup;
      if (setup) begin
         if (paddr == mcrc_pkg::MCRC_MAIN_CTRL_A_OFF) begin
            rd = {30'h0, st_q.main_source_select};
         end else if (paddr == mcrc_pkg::MCRC_MAIN_CTRL_B_OFF) begin
            rd = {27'h0, st_q.pdiv, st_q.pen};
         end else if (paddr == mcrc_pkg::MCRC_MAIN_STATUS_OFF) begin
            rd = {24'h0, st_q.ext_stable, 1'b0, st_q.slow_en, st_q.fast_en, 3'h0,
                  st_q.sw == mcrc_pkg::MCRC_SW_WAIT}; // [RULE_17] [RULE_18]
         end else if (paddr == mcrc_pkg::MCRC_FAST_OSC_CTRL_OFF) begin
            rd = {30'h0, st_q.fast_keep, 1'b0};
         end else if (paddr == mcrc_pkg::MCRC_SLOW_OSC_CTRL_OFF) begin
            rd = {30'h0, st_q.slow_keep, 1'b0};
         end else if (paddr == mcrc_pkg::MCRC_SLEEP_CTRL_OFF) begin
            rd = {30'h0, st_q.sleep_mode};
         end else begin
            rd = 32'h0000_0000;
         end
         st_d.rdata = rd;
      end
      // Key opens a short window counted in processor instructions
      if (cpu_instr_done && prot_ok) begin
         st_d.key_cnt = st_q.key_cnt - 3'h1;
      end
      if (wr && paddr == mcrc_pkg::MCRC_KEY_OFF && pwdata[7:0] == mcrc_pkg::MCRC_IO_KEY) begin
         st_d.key_cnt = mcrc_pkg::MCRC_KEY_WINDOW; // [RULE_21]
      end
      if (wr && prot_ok) begin
         if (paddr == mcrc_pkg::MCRC_MAIN_CTRL_A_OFF) begin
            st_d.key_cnt = 3'h0;
            // A pending external switch locks the selection until the switch completes
            // Code 2 has no source behind it; the old selection stays
            if (st_q.sw != mcrc_pkg::MCRC_SW_WAIT && pwdata[1:0] != 2'h2) begin // [RULE_16]
               st_d.main_source_select = pwdata[1:0]; // [RULE_08] [RULE_14]
            end
         end else if (paddr == mcrc_pkg::MCRC_MAIN_CTRL_B_OFF) begin
            st_d.key_cnt = 3'h0;
            st_d.pen = pwdata[0];
            st_d.pdiv = pwdata[mcrc_pkg::MCRC_PDIV_POS +: 4];
         end else if (paddr == mcrc_pkg::MCRC_FAST_OSC_CTRL_OFF) begin
            st_d.key_cnt = 3'h0;
            st_d.fast_keep = pwdata[1];
         end else if (paddr == mcrc_pkg::MCRC_SLOW_OSC_CTRL_OFF) begin
            st_d.key_cnt = 3'h0;
            st_d.slow_keep = pwdata[1];
         end
      end
      if (wr && paddr == mcrc_pkg::MCRC_SLEEP_CTRL_OFF) begin
         st_d.sleep_mode = pwdata[1:0];
      end
      // ----------------------------------------
      // Source switch
      // ----------------------------------------
      st_d.ext_sync1 = external_clock_input;
      st_d.ext_sync2 = st_q.ext_sync1;
      st_d.ext_prev = st_q.ext_sync2;
      case (st_q.sw)
         mcrc_pkg::MCRC_SW_IDLE: begin
            if (st_d.main_source_select == mcrc_pkg::MCRC_SRC_EXT) begin
               st_d.sw = mcrc_pkg::MCRC_SW_WAIT;
               st_d.edge_cnt = 8'h00;
            end else begin
               st_d.active_src = st_d.main_source_select; // [RULE_14]
            end
         end
         mcrc_pkg::MCRC_SW_WAIT: begin
            if (st_q.ext_start != mcrc_pkg::MCRC_EXT_START_CYC) begin
               st_d.ext_start = st_q.ext_start + 2'h1; // [RULE_22]
            end else if (st_q.ext_sync2 && !st_q.ext_prev) begin
               st_d.edge_cnt = st_q.edge_cnt + 8'h01; // [RULE_24]
               if (st_d.edge_cnt == 8'(EXT_EDGES)) begin
                  st_d.sw = mcrc_pkg::MCRC_SW_EXT; // [RULE_15]
                  st_d.active_src = mcrc_pkg::MCRC_SRC_EXT;
                  st_d.ext_stable = 1'b1; // [RULE_18]
               end
            end
         end
         // No fallback: only reset leaves the external source
         default: begin
            st_d.active_src = mcrc_pkg::MCRC_SRC_EXT; // [RULE_19]
         end
      endcase
      // ----------------------------------------
      // Requests and oscillator gating
      // ----------------------------------------
      st_d.cnt_req = counter_enabled; // [RULE_06]
      st_d.wdt_req = watchdog_enabled; // [RULE_07]
      st_d.bod_req = brownout_sampled; // [RULE_07]
      ext_wanted = st_q.sw != mcrc_pkg::MCRC_SW_IDLE || (counter_enabled && counter_uses_ext);
      case (st_q.sleep_mode)
         mcrc_pkg::MCRC_SLP_ACTIVE, mcrc_pkg::MCRC_SLP_IDLE: main_needed = 1'b1; // [RULE_11]
         mcrc_pkg::MCRC_SLP_STANDBY: main_needed = periph_main_req ||
            (st_q.active_src == mcrc_pkg::MCRC_SRC_FAST && st_q.fast_keep) ||
            (st_q.active_src == mcrc_pkg::MCRC_SRC_SLOW && st_q.slow_keep); // [RULE_12]
         default: main_needed = memory_busy; // [RULE_13]
      endcase
      st_d.main_run = main_needed;
      // Requests routed to their own source; idle sources off
      // Enables follow the next source, so the mux never picks a stopped oscillator
      st_d.fast_en = (main_needed && st_d.active_src == mcrc_pkg::MCRC_SRC_FAST) ||
         (st_q.fast_keep && st_q.sleep_mode != 2'h3); // [RULE_01] [RULE_02] [RULE_09] [RULE_10]
      st_d.slow_en = (main_needed && st_d.active_src == mcrc_pkg::MCRC_SRC_SLOW) ||
         (st_q.slow_keep && st_q.sleep_mode != 2'h3) || (counter_enabled && !counter_uses_ext) ||
         watchdog_enabled || brownout_sampled; // [RULE_01] [RULE_02] [RULE_09] [RULE_10]
      st_d.pin_mode = ext_wanted; // [RULE_22]
      // ----------------------------------------
      // Prescaler
      // ----------------------------------------
      div_last = mcrc_div(st_q.pdiv, st_q.pen); // [RULE_03]
      if (!main_needed || st_q.div_cnt >= div_last) begin
         st_d.div_cnt = 6'h00;
      end else begin
         st_d.div_cnt = st_q.div_cnt + 6'h01;
      end
      st_d.per_tick = main_needed && st_q.div_cnt >= div_last; // [RULE_04]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
         st_q.main_source_select <= mcrc_pkg::MCRC_SRC_FAST; // [RULE_20]
         st_q.active_src <= mcrc_pkg::MCRC_SRC_FAST;
         st_q.pdiv <= mcrc_pkg::MCRC_PDIV_RST; // [RULE_20]
         st_q.pen <= mcrc_pkg::MCRC_PEN_RST;
         st_q.sw <= mcrc_pkg::MCRC_SW_IDLE;
         st_q.main_run <= 1'b1;
         st_q.fast_en <= 1'b1;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = 1'b0;
   assign fast_osc_en = st_q.fast_en;
   assign slow_osc_en = st_q.slow_en;
   assign ext_pin_clock_mode = st_q.pin_mode;
   assign main_clk_run = st_q.main_run;
   assign cpu_clk_en = st_q.main_run; // [RULE_05]
   assign per_clk_en = st_q.per_tick; // [RULE_05]
   assign main_src_sel = st_q.active_src;
   assign counter_clk_req = st_q.cnt_req;
   assign watchdog_clock_net_req = st_q.wdt_req;
   assign brownout_clock_net_req = st_q.bod_req;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !clk_en);

   a_pend_lock: assert property (st_q.sw == mcrc_pkg::MCRC_SW_WAIT |=> // [RULE_16]
      st_q.main_source_select == $past(st_q.main_source_select)) else $error("select changed while pending");
   a_ext_fixed: assert property (st_q.sw == mcrc_pkg::MCRC_SW_EXT |=> // [RULE_19]
      main_src_sel == mcrc_pkg::MCRC_SRC_EXT) else $error("left external source");
   a_pend_flag: assert property (setup && paddr == mcrc_pkg::MCRC_MAIN_STATUS_OFF |=> // [RULE_17]
      prdata[0] == ($past(st_q.sw) == mcrc_pkg::MCRC_SW_WAIT)) else $error("pending flag wrong");
   a_run_active: assert property (st_q.sleep_mode == 2'h0 |=> main_clk_run) else $error("main stopped"); // [RULE_11]
   a_pdown_mem: assert property (st_q.sleep_mode == 2'h3 && memory_busy |=> main_clk_run) else $error("stop early"); // [RULE_13]
   a_wdt_req: assert property (watchdog_enabled |=> watchdog_clock_net_req && slow_osc_en) else $error("wdt req"); // [RULE_07]
   a_cnt_req: assert property (counter_enabled |=> counter_clk_req) else $error("counter req"); // [RULE_06]
   a_ext_switch: assert property ($rose(st_q.ext_stable) |-> main_src_sel == mcrc_pkg::MCRC_SRC_EXT) // [RULE_15]
      else $error("stable without switch");
   a_div_range: assert property (per_clk_en && div_last != 6'h00 |=> !per_clk_en) // [RULE_03]
      else $error("tick spacing");
   // ----------------------------------------
   // Source, oscillator, sleep, key and prescaler checks
   // ----------------------------------------
   a_pin_mode: assert property (st_q.sw != mcrc_pkg::MCRC_SW_IDLE |=> ext_pin_clock_mode) // [RULE_22]
      else $error("pin not in clock mode");
   a_cnt_ext: assert property (counter_enabled && counter_uses_ext |=> ext_pin_clock_mode) // [RULE_02]
      else $error("counter request not routed");
   a_bod_req: assert property (brownout_sampled |=> brownout_clock_net_req && slow_osc_en) // [RULE_07]
      else $error("brownout request");
   a_stby_stop: assert property (st_q.sleep_mode == 2'h2 && !periph_main_req && // [RULE_12]
      !st_q.fast_keep && !st_q.slow_keep |=> !main_clk_run) else $error("standby clock left on");
   a_pdown_stop: assert property (st_q.sleep_mode == 2'h3 && !memory_busy |=> !main_clk_run) // [RULE_13]
      else $error("power-down clock left on");
   a_fast_on: assert property (main_src_sel == mcrc_pkg::MCRC_SRC_FAST && main_clk_run |-> fast_osc_en) // [RULE_14]
      else $error("fast source stopped while used");
   a_slow_on: assert property (main_src_sel == mcrc_pkg::MCRC_SRC_SLOW && main_clk_run |-> slow_osc_en) // [RULE_14]
      else $error("slow source stopped while used");
   a_sel_valid: assert property (main_src_sel != 2'h2) // [RULE_08]
      else $error("reserved source code");
   a_key_clear: assert property (wr && prot_ok && paddr == mcrc_pkg::MCRC_MAIN_CTRL_B_OFF |=> // [RULE_21]
      st_q.key_cnt == 3'h0) else $error("key window left open");
   a_per_gate: assert property (!main_clk_run |-> !per_clk_en) // [RULE_04]
      else $error("tick without main clock");
   a_stable_hold: assert property (st_q.ext_stable |=> st_q.ext_stable) // [RULE_18]
      else $error("stable flag dropped");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   c_ext_done: cover property (st_q.sw == mcrc_pkg::MCRC_SW_WAIT ##[1:200] st_q.sw == mcrc_pkg::MCRC_SW_EXT);
   c_standby: cover property (st_q.sleep_mode == 2'h2 && !main_clk_run);
   c_key_write: cover property (wr && prot_ok && paddr == mcrc_pkg::MCRC_MAIN_CTRL_B_OFF);
   c_div_64: cover property (per_clk_en && st_q.pen && st_q.pdiv == 4'h5);
   c_keep_run: cover property (st_q.sleep_mode == 2'h2 && st_q.fast_keep && main_clk_run);
endmodule : mcrc_top
`default_nettype wire
